// File: core/scl_top.sv
`timescale 1ns/1ns
`include "scl_map.svh"
module scl_top #(
	parameter logic [15:0] TO_UNIT_CYC = `SCL_TO_UNIT_CYC
) (
	input  wire logic                     i_clk,           // System clock, 100 MHz
	input  wire logic                     i_reset_n,       // Async reset, low
	input  wire logic                     i_sclk,          // Serial clock pin
	input  wire logic                     i_sdata,         // Serial data pin
	input  wire logic                     i_latch_strobe,  // Latch strobe pin
	input  wire logic                     i_chip_enable,   // Chip enable pin, high = on
	input  wire logic                     i_cp_event,      // Charge pump event pulse, same domain
	output logic                          o_pd_active,     // Device powered down
	output logic                          o_cp_hiz,        // Charge pump output floating
	output logic                          o_counters_load, // R, AB counters held at load
	output logic                          o_timeout_load,  // Timeout counter held at load
	output logic                          o_lock_reset,    // Lock detect reset
	output logic                          o_rf_debias,     // RF input debiased
	output logic                          o_ref_buf_off,   // Reference buffer disabled
	output logic [2:0]                    o_cp_current,    // Selected pump current code
	output logic                          o_fast_active,   // Fastlock current in use
	output logic                          o_align_pulse,   // Internal reset pulse
	output logic [2:0]                    o_mux_select,    // Mux output select
	output logic                          o_polarity,      // Detector polarity bit
	output logic [1:0]                    o_prescaler,     // Prescaler select
	output logic [`SCL_WORD_W-1:0]        o_ref_word,      // Reference counter word
	output logic [`SCL_WORD_W-1:0]        o_ab_word        // AB counter word
);
	typedef struct packed {
		scl_pkg::scl_loop_type  loop;
		logic [`SCL_WORD_W-1:0] ref_word;
		logic [`SCL_WORD_W-1:0] ab_word;
		logic                   fast_req;
		logic                   ab_pending;
		logic                   pd_sync_done;
		logic                   pulse;
		logic [15:0]            unit_cnt;
		logic [4:0]             to_cnt;
		logic                   to_run;
		scl_pkg::scl_status_type st;
		logic                   to_load;
	} scl_top_state_type;

	scl_top_state_type s_q;
	scl_top_state_type s_d;

	logic                   sclk_s;
	logic                   sdata_s;
	logic                   strobe_s;
	logic                   ce_s;
	logic                   word_valid;
	logic [`SCL_WORD_W-1:0] word;

	scl_sync #(.W(4)) u_sync (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_async   ({i_sclk, i_sdata, i_latch_strobe, i_chip_enable}),
		.o_sync    ({sclk_s, sdata_s, strobe_s, ce_s})
	);

	// shift path stays live in power-down
	scl_shift u_shift (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_sclk    (sclk_s),
		.i_sdata   (sdata_s),
		.i_strobe  (strobe_s),
		.o_valid   (word_valid),
		.o_word    (word)
	);

	function automatic scl_pkg::scl_loop_type decode_loop(input logic [`SCL_WORD_W-1:0] w);
		scl_pkg::scl_loop_type l;
		l.prescaler = w[`SCL_B_PRE_HI:`SCL_B_PRE_LO];
		l.pd_sync   = w[`SCL_B_PD_SYNC];
		l.cur2      = w[`SCL_B_CUR2_HI:`SCL_B_CUR2_LO];
		l.cur1      = w[`SCL_B_CUR1_HI:`SCL_B_CUR1_LO];
		l.timeout   = w[`SCL_B_TO_HI:`SCL_B_TO_LO];
		l.fl_mode   = w[`SCL_B_FL_MODE];
		l.fl_en     = w[`SCL_B_FL_EN];
		l.cp_tri    = w[`SCL_B_CP_TRI];
		l.polarity  = w[`SCL_B_POLARITY];
		l.mux_sel   = w[`SCL_B_MUX_HI:`SCL_B_MUX_LO];
		l.pd_arm    = w[`SCL_B_PD_ARM];
		l.cnt_reset = w[`SCL_B_CNT_RESET];
		return l;
	endfunction : decode_loop

	logic pd_async;
	logic sync_armed;
	logic ab_wr;
	logic pd_now;
	logic fast_on;
	logic to_tick;

	always_comb begin
		s_d       = s_q;
		s_d.pulse = 1'b0;

		if (word_valid) begin
			if (word[1:0] == `SCL_SEL_LOOP) begin
				s_d.loop         = decode_loop(word);
				s_d.pd_sync_done = 1'b0;
			end else if (word[1:0] == `SCL_SEL_INIT) begin
				s_d.loop         = decode_loop(word);
				s_d.pulse        = 1'b1;
				s_d.ab_pending   = 1'b1;
				s_d.pd_sync_done = 1'b0;
			end else if (word[1:0] == `SCL_SEL_AB) begin
				s_d.ab_word  = word;
				// fast request written from AB word
				s_d.fast_req = word[`SCL_B_FAST_REQ];
				s_d.to_cnt   = '0;
				s_d.unit_cnt = '0;
				// first AB after init pulses once
				if (s_q.ab_pending) begin
					s_d.pulse      = 1'b1;
					s_d.ab_pending = 1'b0;
				end
			end else begin
				s_d.ref_word = word;
			end
		end

		pd_async = s_q.loop.pd_arm && !s_q.loop.pd_sync;
		// synchronous power-down waits for pump event
		sync_armed = s_q.loop.pd_arm && s_q.loop.pd_sync && !s_q.pd_sync_done;
		// init pulse also triggers sync power-down
		// Armed from the live latch, so the pulse issued with the init load counts
		if (sync_armed && (i_cp_event || s_q.pulse)) begin
			s_d.pd_sync_done = 1'b1;
		end
		if (!(s_q.loop.pd_arm && s_q.loop.pd_sync)) begin
			s_d.pd_sync_done = 1'b0;
		end
		pd_now = !ce_s || pd_async || s_q.pd_sync_done;

		fast_on = s_q.loop.fl_en && s_q.fast_req && !pd_now;

		ab_wr   = word_valid && (word[1:0] == `SCL_SEL_AB);
		to_tick = 1'b0;
		// An AB word write wins over a timeout landing in the same cycle
		if (fast_on && s_q.loop.fl_mode && !ab_wr) begin
			if (s_q.unit_cnt == TO_UNIT_CYC - 16'h0001) begin
				s_d.unit_cnt = '0;
				to_tick      = 1'b1;
			end else begin
				s_d.unit_cnt = s_q.unit_cnt + 16'h0001;
			end
			if (to_tick) begin
				s_d.to_cnt = s_q.to_cnt + 5'h01;
				if (s_q.to_cnt >= {1'b0, s_q.loop.timeout}) begin
					s_d.fast_req = 1'b0;
					s_d.to_cnt   = '0;
				end
			end
		end else if (!ab_wr) begin
			s_d.unit_cnt = '0;
			s_d.to_cnt   = '0;
		end

		s_d.st.pd_active = pd_now;
		s_d.st.cp_hiz = s_q.loop.cp_tri || pd_now || s_q.loop.cnt_reset || s_q.pulse;
		// release from load point keeps alignment
		s_d.st.counters_load = s_q.loop.cnt_reset || pd_now || s_q.pulse;
		s_d.to_load          = pd_now || s_q.pulse || !s_q.loop.fl_mode;
		s_d.st.lock_reset    = pd_now;
		// analog front parts off in power-down
		s_d.st.rf_debias     = pd_now;
		s_d.st.ref_buf_off   = pd_now;
		s_d.st.fast_active = fast_on;
		s_d.st.cp_current  = fast_on ? s_q.loop.cur2 : s_q.loop.cur1;
	end

	// latches have no tie to chip enable
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_pd_active     = s_q.st.pd_active;
	assign o_cp_hiz        = s_q.st.cp_hiz;
	assign o_counters_load = s_q.st.counters_load;
	assign o_timeout_load  = s_q.to_load;
	assign o_lock_reset    = s_q.st.lock_reset;
	assign o_rf_debias     = s_q.st.rf_debias;
	assign o_ref_buf_off   = s_q.st.ref_buf_off;
	assign o_cp_current    = s_q.st.cp_current;
	assign o_fast_active   = s_q.st.fast_active;
	assign o_align_pulse   = s_q.pulse;
	assign o_mux_select    = s_q.loop.mux_sel;
	assign o_polarity      = s_q.loop.polarity;
	assign o_prescaler     = s_q.loop.prescaler;
	assign o_ref_word      = s_q.ref_word;
	assign o_ab_word       = s_q.ab_word;
endmodule : scl_top

// File: common/scl_map.svh
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
`define SCL_WORD_W        24
`define SCL_SEL_REF       2'h0
`define SCL_SEL_AB        2'h1
`define SCL_SEL_LOOP      2'h2
`define SCL_SEL_INIT      2'h3
`define SCL_B_CNT_RESET   2
`define SCL_B_PD_ARM      3
`define SCL_B_MUX_LO      4
`define SCL_B_MUX_HI      6
`define SCL_B_POLARITY    7
`define SCL_B_CP_TRI      8
`define SCL_B_FL_EN       9
`define SCL_B_FL_MODE     10
`define SCL_B_TO_LO       11
`define SCL_B_TO_HI       14
`define SCL_B_CUR1_LO     15
`define SCL_B_CUR1_HI     17
`define SCL_B_CUR2_LO     18
`define SCL_B_CUR2_HI     20
`define SCL_B_PD_SYNC     21
`define SCL_B_PRE_LO      22
`define SCL_B_PRE_HI      23
`define SCL_B_FAST_REQ    21
`define SCL_LOOP_RESET    24'h000000
`define SCL_TO_UNIT_CYC   16'h0010
`endif

// File: common/scl_pkg.sv
package scl_pkg;
	typedef struct packed {
		logic [1:0] prescaler;
		logic       pd_sync;
		logic [2:0] cur2;
		logic [2:0] cur1;
		logic [3:0] timeout;
		logic       fl_mode;
		logic       fl_en;
		logic       cp_tri;
		logic       polarity;
		logic [2:0] mux_sel;
		logic       pd_arm;
		logic       cnt_reset;
	} scl_loop_type;

	typedef struct packed {
		logic       pd_active;
		logic       cp_hiz;
		logic       counters_load;
		logic       lock_reset;
		logic       rf_debias;
		logic       ref_buf_off;
		logic [2:0] cp_current;
		logic       fast_active;
	} scl_status_type;
endpackage : scl_pkg

// File: core/scl_sync.sv
`timescale 1ns/1ns
module scl_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,     // System clock
	input  wire logic         i_reset_n, // Async reset, low
	input  wire logic [W-1:0] i_async,   // Pin levels
	output logic      [W-1:0] o_sync     // Synchronised levels
);
	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule : scl_sync

// File: core/scl_shift.sv
`timescale 1ns/1ns
`include "scl_map.svh"
module scl_shift (
	input  wire logic                     i_clk,     // System clock
	input  wire logic                     i_reset_n, // Async reset, low
	input  wire logic                     i_sclk,    // Synchronised serial clock
	input  wire logic                     i_sdata,   // Synchronised serial data
	input  wire logic                     i_strobe,  // Synchronised latch strobe
	output logic                          o_valid,   // Word ready pulse
	output logic [`SCL_WORD_W-1:0]        o_word     // Shifted word
);
	typedef struct packed {
		logic                   sclk;
		logic                   strobe;
		logic [`SCL_WORD_W-1:0] sr;
		logic                   valid;
	} scl_shift_state_type;

	scl_shift_state_type s_q;
	scl_shift_state_type s_d;

	always_comb begin
		s_d        = s_q;
		s_d.sclk   = i_sclk;
		s_d.strobe = i_strobe;
		s_d.valid  = 1'b0;
		if (i_sclk && !s_q.sclk) begin
			s_d.sr = {s_q.sr[`SCL_WORD_W-2:0], i_sdata};
		end
		if (i_strobe && !s_q.strobe) begin
			s_d.valid = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_valid = s_q.valid;
	assign o_word  = s_q.sr;
endmodule : scl_shift

// File: test/scl_assertions.sv
`timescale 1ns/1ns
module scl_assertions #(
	parameter logic [15:0] TO_UNIT_CYC = 16'h0010
) (
	input wire logic        i_clk,           // Clock
	input wire logic        i_reset_n,       // Reset, low
	input wire logic        i_chip_enable,   // Chip enable pin
	input wire logic        i_latch_strobe,  // Latch strobe pin
	input wire logic        o_pd_active,     // Powered down
	input wire logic        o_cp_hiz,        // Pump floating
	input wire logic        o_counters_load, // Counters at load
	input wire logic        o_timeout_load,  // Timer at load
	input wire logic        o_lock_reset,    // Lock detect reset
	input wire logic        o_rf_debias,     // RF input off
	input wire logic        o_ref_buf_off,   // Ref buffer off
	input wire logic        o_fast_active,   // Fast current
	input wire logic        o_align_pulse,   // Reset pulse
	input wire logic [23:0] o_ref_word,      // Reference word
	input wire logic [23:0] o_ab_word        // AB word
);
	logic       strb_q;
	logic [3:0] since_q;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// Cycles since the strobe pin last rose, saturating
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			strb_q  <= 1'b0;
			since_q <= 4'hf;
		end else begin
			strb_q <= i_latch_strobe;
			if (i_latch_strobe && !strb_q)
				since_q <= 4'h0;
			else if (since_q != 4'hf)
				since_q <= since_q + 4'h1;
		end
	end

	ce_power_down_a: assert property ($fell(i_chip_enable) |-> ##[1:6] o_pd_active)
		else $error("chip enable low without power down");
	pd_pump_float_a: assert property (o_pd_active |-> o_cp_hiz)
		else $error("pump driven in power down");
	pd_side_effects_a: assert property (o_pd_active |-> o_counters_load && o_timeout_load
		&& o_lock_reset && o_rf_debias && o_ref_buf_off) else $error("power down effects missing");
	pulse_width_a: assert property (o_align_pulse |=> !o_align_pulse)
		else $error("reset pulse longer than one cycle");
	pulse_effects_a: assert property (o_align_pulse |-> ##[0:2] (o_cp_hiz && o_counters_load))
		else $error("reset pulse without load and float");
	ref_word_cause_a: assert property ($changed(o_ref_word) |-> since_q <= 4'hc)
		else $error("reference word changed without strobe");
	ab_word_cause_a: assert property ($changed(o_ab_word) |-> since_q <= 4'hc)
		else $error("AB word changed without strobe");
	pd_no_fast_a: assert property (o_pd_active [*3] |-> !o_fast_active)
		else $error("fast current during power down");

	cover property (o_align_pulse);
	cover property ($fell(o_fast_active) && !o_pd_active);
	cover property ($rose(o_pd_active) && i_chip_enable);
endmodule : scl_assertions

bind scl_top scl_assertions #(.TO_UNIT_CYC(TO_UNIT_CYC)) scl_assertions_i (
	.i_clk(i_clk), .i_reset_n(i_reset_n), .i_chip_enable(i_chip_enable),
	.i_latch_strobe(i_latch_strobe), .o_pd_active(o_pd_active), .o_cp_hiz(o_cp_hiz),
	.o_counters_load(o_counters_load), .o_timeout_load(o_timeout_load),
	.o_lock_reset(o_lock_reset), .o_rf_debias(o_rf_debias), .o_ref_buf_off(o_ref_buf_off),
	.o_fast_active(o_fast_active), .o_align_pulse(o_align_pulse), .o_ref_word(o_ref_word),
	.o_ab_word(o_ab_word)
);

// File: test/scl_host_model.sv
`timescale 1ns/1ns
module scl_host_model (
	input  wire logic i_clk,    // Bench clock
	output logic      o_sclk,   // Serial clock
	output logic      o_sdata,  // Serial data
	output logic      o_strobe  // Latch strobe
);
	initial begin
		o_sclk = 1'b0;
		o_sdata = 1'b0;
		o_strobe = 1'b0;
	end

	// Eight clocks per half period: 160 ns link clock, idle low between words
	task automatic send(input logic [23:0] w);
		@(posedge i_clk) #1;
		for (int i = 23; i >= 0; i--) begin
			o_sdata = w[i];
			repeat (8) @(posedge i_clk);
			#1 o_sclk = 1'b1;
			repeat (8) @(posedge i_clk);
			#1 o_sclk = 1'b0;
		end
		// Undriven data must not echo the last bit
		o_sdata = ~w[0];
		repeat (8) @(posedge i_clk);
		#1 o_strobe = 1'b1;
		repeat (8) @(posedge i_clk);
		#1 o_strobe = 1'b0;
	endtask : send
endmodule : scl_host_model

// File: test/tb_top.sv
`timescale 1ns/1ns
`include "scl_map.svh"
module tb_top;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_chip_enable = 1'b1;
	logic i_cp_event = 1'b0;
	logic sclk, sdata, strobe, o_pd_active, o_cp_hiz, o_counters_load, o_timeout_load;
	logic o_lock_reset, o_rf_debias, o_ref_buf_off, o_fast_active, o_align_pulse, o_polarity;
	logic [2:0] o_cp_current, o_mux_select;
	logic [1:0] o_prescaler;
	logic [23:0] o_ref_word, o_ab_word, eref, eab;
	logic [53:0] snap, prev, notes[$];
	logic [2:0] m = 3'h0;
	scl_pkg::scl_loop_type lp;
	int miscompares = 0, num_checks = 0, pulses = 0, cyc = 0;

	always #5 i_clk = ~i_clk;

	scl_host_model scl_host_model_i (.i_clk(i_clk), .o_sclk(sclk), .o_sdata(sdata),
		.o_strobe(strobe));
	scl_top #(.TO_UNIT_CYC(16'h0004)) scl_top_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_sclk(sclk), .i_sdata(sdata), .i_latch_strobe(strobe), .i_chip_enable(i_chip_enable),
		.i_cp_event(i_cp_event), .o_pd_active(o_pd_active), .o_cp_hiz(o_cp_hiz),
		.o_counters_load(o_counters_load), .o_timeout_load(o_timeout_load),
		.o_lock_reset(o_lock_reset), .o_rf_debias(o_rf_debias), .o_ref_buf_off(o_ref_buf_off),
		.o_cp_current(o_cp_current), .o_fast_active(o_fast_active),
		.o_align_pulse(o_align_pulse), .o_mux_select(o_mux_select), .o_polarity(o_polarity),
		.o_prescaler(o_prescaler), .o_ref_word(o_ref_word), .o_ab_word(o_ab_word));

	task automatic finish_test;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string n, input logic [53:0] s, input logic [53:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Status order: pd, float, counters load, fast, current code
	task automatic st(input logic [6:0] e);
		#1;
		chk("status", 54'({o_pd_active, o_cp_hiz, o_counters_load, o_fast_active, o_cp_current}), 54'(e));
	endtask : st

	// Loop and init words come from lp with a fresh mux code so every load is visible
	task automatic wr(input logic [1:0] s, input logic g = 1'b0);
		logic [23:0] w;
		if (s[1]) begin
			lp.mux_sel = m;
			m++;
			w = {lp, s};
		end else begin
			w = 24'($urandom);
			w[1:0] = s;
			w[`SCL_B_FAST_REQ] = g;
			if (s[0]) eab = w;
			else eref = w;
		end
		notes.push_back({eref, eab & 24'hdfffff, lp.mux_sel, lp.polarity, lp.prescaler});
		scl_host_model_i.send(w);
		repeat (4) @(posedge i_clk);
	endtask : wr

	always @(posedge i_clk) begin
		cyc++;
		if (o_align_pulse === 1'b1) pulses++;
		if (cyc == 60000) begin
			miscompares++;
			finish_test();
		end
	end

	// Fast request bit is masked, though the timer clears only fast_req, never the bit held in o_ab_word
	always @(posedge i_clk) begin
		#2;
		snap = {o_ref_word, o_ab_word & 24'hdfffff, o_mux_select, o_polarity, o_prescaler};
		if (i_reset_n && snap !== prev) begin
			if (notes.size() == 0) chk("unexpected", snap, prev);
			else chk("fields", snap, notes.pop_front());
		end
		prev = snap;
	end

	initial begin
		void'($urandom(32'h7439));
		lp = '0;
		lp.prescaler = 2'h1;
		lp.cur1 = 3'h2;
		lp.cur2 = 3'h5;
		eref = '0;
		eab = '0;
		repeat (2) @(posedge i_clk);
		#1 i_reset_n = 1'b1;
		repeat (4) @(posedge i_clk);
		st(7'h00);
		wr(`SCL_SEL_INIT);
		chk("pulses", 54'(pulses), 54'h1);
		wr(`SCL_SEL_LOOP);
		wr(`SCL_SEL_REF);
		wr(`SCL_SEL_AB);
		wr(`SCL_SEL_AB);
		chk("pulses", 54'(pulses), 54'h2);
		st(7'h02);
		lp.fl_en = 1'b1;
		wr(`SCL_SEL_LOOP);
		wr(`SCL_SEL_AB, 1'b1);
		st(7'h0d);
		wr(`SCL_SEL_AB, 1'b0);
		st(7'h02);
		lp.fl_en = 1'b0;
		wr(`SCL_SEL_LOOP);
		wr(`SCL_SEL_AB, 1'b1);
		st(7'h02);
		wr(`SCL_SEL_AB, 1'b0);
		lp.fl_en = 1'b1;
		lp.fl_mode = 1'b1;
		lp.timeout = 4'h5;
		wr(`SCL_SEL_LOOP);
		wr(`SCL_SEL_AB, 1'b1);
		st(7'h0d);
		repeat (40) @(posedge i_clk);
		st(7'h02);
		lp.fl_en = 1'b0;
		lp.fl_mode = 1'b0;
		lp.cnt_reset = 1'b1;
		wr(`SCL_SEL_LOOP);
		st(7'h32);
		lp.cnt_reset = 1'b0;
		lp.cp_tri = 1'b1;
		wr(`SCL_SEL_LOOP);
		st(7'h22);
		lp.cp_tri = 1'b0;
		lp.pd_arm = 1'b1;
		wr(`SCL_SEL_LOOP);
		st(7'h72);
		wr(`SCL_SEL_REF);
		lp.pd_arm = 1'b0;
		wr(`SCL_SEL_LOOP);
		st(7'h02);
		lp.pd_arm = 1'b1;
		lp.pd_sync = 1'b1;
		wr(`SCL_SEL_LOOP);
		st(7'h02);
		i_cp_event = 1'b1;
		@(posedge i_clk) #1 i_cp_event = 1'b0;
		repeat (4) @(posedge i_clk);
		st(7'h72);
		lp.pd_arm = 1'b0;
		lp.pd_sync = 1'b0;
		wr(`SCL_SEL_LOOP);
		#1 i_chip_enable = 1'b0;
		repeat (6) @(posedge i_clk);
		st(7'h72);
		wr(`SCL_SEL_REF);
		#1 i_chip_enable = 1'b1;
		repeat (6) @(posedge i_clk);
		st(7'h02);
		lp.pd_arm = 1'b1;
		lp.pd_sync = 1'b1;
		wr(`SCL_SEL_INIT);
		st(7'h72);
		chk("notes", 54'(notes.size()), 54'h0);
		finish_test();
	end
endmodule : tb_top
